// ---- bcs_attr_ctrl.sv ----
// per-character attribute tracking from bit eight or shift codes
module bcs_attr_ctrl
(
    // clock and reset
    input  wire logic       core_clk_i,
    input  wire logic       reset_n_i,
    // configuration
    input  wire logic       src_bit_eight_i,
    input  wire logic       ff_init_enable_i,
    // received characters
    input  wire logic       rx_valid_i,
    input  wire logic [7:0] rx_data_i,
    // decoded character
    output logic            char_valid_o,
    output logic [6:0]      char_code_o,
    output logic            char_attr_o,
    output logic            init_pulse_o
);
    logic shift_out;
    logic is_so;
    logic is_si;
    logic is_ff;
    logic next_attr;

    // shift codes compare only the seven-bit code
    assign is_so     = rx_data_i[6:0] == bcs_pkg::CHAR_SO[6:0];
    assign is_si     = rx_data_i[6:0] == bcs_pkg::CHAR_SI[6:0];
    assign is_ff     = rx_data_i[6:0] == bcs_pkg::CHAR_FF[6:0];
    assign next_attr = src_bit_eight_i ? rx_data_i[bcs_pkg::ATTR_BIT] : shift_out;

    always_ff @(posedge core_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            shift_out    <= 1'b0;
            char_valid_o <= 1'b0;
            char_code_o  <= 7'h00;
            char_attr_o  <= 1'b0;
            init_pulse_o <= 1'b0;
        end
        else
        begin
            if (rx_valid_i && !src_bit_eight_i && is_so)
                shift_out <= 1'b1;
            else if (rx_valid_i && !src_bit_eight_i && is_si)
                shift_out <= 1'b0;
            // in shift-code mode the shift codes themselves are not displayed
            char_valid_o <= rx_valid_i && (src_bit_eight_i || !(is_so || is_si));
            if (rx_valid_i)
            begin
                char_code_o <= rx_data_i[6:0];
                char_attr_o <= next_attr;
            end
            init_pulse_o <= rx_valid_i && ff_init_enable_i && is_ff;
        end
    end
endmodule

// ---- bcs_host_model.sv ----
// host serial line feeding received characters into the device
module bcs_host_model
(
    // clock and device fill status
    input  wire logic       core_clk_i,
    input  wire logic       fill_busy_i,
    // received character stream
    output logic            rx_valid_o,
    output logic [7:0]      rx_data_o
);
    timeunit 1ns;
    timeprecision 100ps;

    initial
    begin
        rx_valid_o = 1'b0;
        rx_data_o  = 8'h00;
    end

    // host holds a character while fill busy is high; the two sent straight after form feed pass that check before busy rises
    task automatic send(input logic [7:0] b);
        while (fill_busy_i === 1'b1)
            @(posedge core_clk_i);
        @(posedge core_clk_i);
        #1;
        rx_valid_o = 1'b1;
        rx_data_o  = b;
    endtask

    // released data shows the inverse so a stale byte never looks valid
    task automatic idle();
        @(posedge core_clk_i);
        #1;
        rx_valid_o = 1'b0;
        rx_data_o  = ~rx_data_o;
    endtask
endmodule

// ---- bcs_pkg.sv ----
// What this block does
// - all rates divide from one 13.5168 MHz crystal
// - nine rates, 150 up to 38400 bps
// - transmit and receive rates chosen independently
// - external clock drives both, no internal rate
// - default straps select 9600 for both
// - attribute source is bit eight or shift codes
// - default attribute source is shift codes
// - attribute type blink or reverse, blink default
// - screen polarity strap: present forward, absent reverse
// - disable strap suppresses half intensity
// - charset strap: present standard, absent alternate
// - default format eight bits, no parity
// - default remote init on form feed
// - form feed reinitialises; host waits 34 ms fill
// - eight-bit mode: bit eight selects attribute
// - shift-out sets, shift-in clears attribute
// - parity straps pick odd, even or none
package bcs_pkg;
    localparam int unsigned CLK_HZ      = 100_000_000;
    localparam int unsigned XTAL_HZ     = 13_516_800;
    // 16x oversampling ticks: xtal / 16 / rate; 38400 needs divide by 22
    localparam int unsigned OVERSAMPLE  = 16;
    localparam int unsigned BASE_DIV    = XTAL_HZ / (OVERSAMPLE * 38400);
    localparam int unsigned NUM_RATES   = 9;
    localparam int unsigned FILL_MS     = 34;
    localparam int unsigned FILL_CYC    = (CLK_HZ / 1000) * FILL_MS;
    // phase accumulator steps xtal out of the 100 MHz core clock
    localparam logic [31:0] XTAL_STEP   = 32'h229A_5EBB; // round(2^32*xtal/clk)
    localparam logic [3:0]  RATE_9600   = 4'h6;
    localparam logic [3:0]  RATE_EXT    = 4'h9;
    localparam logic [7:0]  CHAR_FF     = 8'h0C;
    localparam logic [7:0]  CHAR_SO     = 8'h0E;
    localparam logic [7:0]  CHAR_SI     = 8'h0F;
    localparam int unsigned ATTR_BIT    = 7;

    typedef enum logic [1:0]
    {
        BCS_PAR_NONE = 2'b00,
        BCS_PAR_ODD  = 2'b01,
        BCS_PAR_EVEN = 2'b10
    } bcs_parity_t;

    // decoded, latched option set
    typedef struct packed
    {
        logic [3:0]  tx_rate;
        logic [3:0]  rx_rate;
        logic        src_bit_eight;
        logic        attr_reverse;
        logic        forward_video;
        logic        half_int_enable;
        logic        charset_std;
        bcs_parity_t parity;
        logic        ff_init_enable;
    } bcs_cfg_t;
endpackage

// ---- bcs_rate_divider.sv ----
// crystal-rate prescale and binary chain producing nine tick pulses
module bcs_rate_divider
(
    // clock and reset
    input  wire logic       core_clk_i,
    input  wire logic       reset_n_i,
    // one-cycle ticks, index 0 = 150 .. 8 = 38400
    output logic [8:0]      rate_tick_o
);
    logic [31:0] phase;
    logic [32:0] next_phase;
    logic        xtal_tick;
    logic [4:0]  pre_cnt;
    logic        pre_tick;
    logic [7:0]  chain;
    logic [7:0]  next_chain;

    // phase accumulator emulates the crystal edge rate
    assign next_phase = {1'b0, phase} + {1'b0, bcs_pkg::XTAL_STEP};
    assign xtal_tick  = next_phase[32];
    assign pre_tick   = xtal_tick && (pre_cnt == 5'(bcs_pkg::BASE_DIV - 1));
    assign next_chain = chain + 8'h01;

    always_ff @(posedge core_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            phase   <= 32'h0000_0000;
            pre_cnt <= 5'h00;
            chain   <= 8'h00;
        end
        else
        begin
            phase <= next_phase[31:0];
            if (xtal_tick)
                pre_cnt <= pre_tick ? 5'h00 : pre_cnt + 5'h01;
            if (pre_tick)
                chain <= next_chain;
        end
    end

    // each binary stage halves the rate; a tick marks its carry
    assign rate_tick_o[8] = pre_tick;
    genvar g;
    generate
        for (g = 0; g < 8; g++)
        begin : g_stage
            assign rate_tick_o[7 - g] = pre_tick && (&chain[g:0]);
        end
    endgenerate
endmodule

// ---- bcs_tb_top.sv ----
module bcs_tb_top;
    timeunit 1ns;
    timeprecision 100ps;

    logic              core_clk_i;
    logic              reset_n_i;
    logic              ext_clk_pin_i;
    logic              ext_run;
    logic [3:0]        tx_rate_strap_i;
    logic [3:0]        rx_rate_strap_i;
    logic [9:0]        opt;
    logic [1:0]        parity_strap_i;
    logic              bit_eight_source_post_i, shift_code_source_post_i;
    logic              reverse_attr_post_i, blink_attr_post_i, screen_polarity_strap_i;
    logic              half_intensity_disable_strap_i, charset_select_strap_i;
    logic              formfeed_init_strap_i, rx_valid_i, tx_tick_o, rx_tick_o;
    logic              attr_blink_o, attr_reverse_o, char_valid_o, char_attr_o;
    logic              init_pulse_o, fill_busy_o;
    logic [7:0]        rx_data_i;
    logic [6:0]        char_code_o;
    bcs_pkg::bcs_cfg_t cfg_o;
    int                errors;
    int                check_count;
    int                seed;
    logic [7:0]        b;
    logic [7:0]        exp_q[$];

    // strap word: b8, shift, rev, blink, polarity, half-dis, charset, parity, ff
    assign {bit_eight_source_post_i, shift_code_source_post_i, reverse_attr_post_i,
            blink_attr_post_i, screen_polarity_strap_i, half_intensity_disable_strap_i,
            charset_select_strap_i, parity_strap_i, formfeed_init_strap_i} = opt;

    bcs_top u_dut
    (
        .core_clk_i, .reset_n_i, .tx_rate_strap_i, .rx_rate_strap_i,
        .bit_eight_source_post_i, .shift_code_source_post_i, .reverse_attr_post_i,
        .blink_attr_post_i, .screen_polarity_strap_i, .half_intensity_disable_strap_i,
        .charset_select_strap_i, .parity_strap_i, .formfeed_init_strap_i,
        .ext_clk_pin_i, .rx_valid_i, .rx_data_i, .tx_tick_o, .rx_tick_o, .cfg_o,
        .attr_blink_o, .attr_reverse_o, .char_valid_o, .char_code_o, .char_attr_o,
        .init_pulse_o, .fill_busy_o
    );

    bcs_host_model u_host
    (
        .core_clk_i  (core_clk_i),
        .fill_busy_i (fill_busy_o),
        .rx_valid_o  (rx_valid_i),
        .rx_data_o   (rx_data_i)
    );

    initial
    begin
        core_clk_i = 1'b0;
        forever #5 core_clk_i = ~core_clk_i;
    end

    // external pin, slightly off the core grid, idle low when unused
    initial
    begin
        ext_clk_pin_i = 1'b0;
        forever
        begin
            #500.3;
            ext_clk_pin_i = ext_run ? ~ext_clk_pin_i : 1'b0;
        end
    end

    task automatic results();
        $display("checks=%0d errors=%0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic note(input bit bad, input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (bad)
        begin
            errors++;
            $display("Error t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic chk_cfg(input bcs_pkg::bcs_cfg_t got, input bcs_pkg::bcs_cfg_t e);
        note(got !== e, 32'(got), 32'(e));
    endtask

    task automatic chk_char(input logic [7:0] got, input logic [7:0] e);
        note(got !== e, 32'(got), 32'(e));
    endtask

    task automatic chk_bit(input logic got, input logic e);
        note(got !== e, 32'(got), 32'(e));
    endtask

    // period tolerance covers the one-cycle grid of the emulated crystal
    task automatic chk_per(input int got, input real e);
        note(got < 0 || (got - e) > 2.0 || (e - got) > 2.0, got, $rtoi(e));
    endtask

    task automatic chk_opts(input bcs_pkg::bcs_cfg_t e);
        chk_cfg(cfg_o, e);
        chk_bit(attr_reverse_o, e.attr_reverse);
        chk_bit(attr_blink_o, ~e.attr_reverse);
    endtask

    function automatic real per(input int k);
        return real'(bcs_pkg::CLK_HZ) / (real'(bcs_pkg::OVERSAMPLE) * (150 << k));
    endfunction

    // straps settle before release and stay past the capture edge
    task automatic do_reset(input logic [3:0] tx, input logic [3:0] rx, input logic [9:0] o);
        @(posedge core_clk_i);
        #1;
        reset_n_i = 1'b0;
        tx_rate_strap_i = tx;
        rx_rate_strap_i = rx;
        opt = o;
        repeat (16) @(posedge core_clk_i);
        #2;
        chk_cfg(cfg_o, 16'h6639);
        @(posedge core_clk_i);
        #1;
        reset_n_i = 1'b1;
        repeat (6) @(posedge core_clk_i);
        #1;
    endtask

    // time between two ticks; a tick held two cycles is a fault
    task automatic meas(input bit rx, input real e);
        int   cnt;
        int   first;
        logic tk;
        logic prev;
        cnt = 0;
        first = -1;
        prev = 1'b0;
        while (cnt < 50000)
        begin
            @(posedge core_clk_i);
            #2;
            cnt++;
            tk = rx ? rx_tick_o : tx_tick_o;
            if (tk === 1'b1 && prev === 1'b1)
                chk_bit(1'b0, 1'b1);
            prev = tk;
            if (tk === 1'b1 && first >= 0)
            begin
                chk_per(cnt - first, e);
                return;
            end
            if (tk === 1'b1)
                first = cnt;
        end
        chk_per(-1, e);
    endtask

    task automatic put(input logic [7:0] d, input logic [7:0] e);
        exp_q.push_back(e);
        u_host.send(d);
    endtask

    // every decoded character is matched against the oldest note
    always
    begin
        @(posedge core_clk_i);
        #2;
        if (char_valid_o === 1'b1)
            chk_char({char_attr_o, char_code_o}, exp_q.size() > 0 ? exp_q.pop_front() : 8'hXX);
    end

    // two periods each at 300 and 600 dominate; the rest is about twelve thousand
    initial
    begin
        repeat (90000) @(posedge core_clk_i);
        errors++;
        results();
    end

    initial
    begin
        seed = 36144;
        errors = 0;
        check_count = 0;
        reset_n_i = 1'b0;
        ext_run = 1'b0;
        tx_rate_strap_i = 4'h6;
        rx_rate_strap_i = 4'h6;
        opt = 10'h169;
        do_reset(4'h6, 4'h6, 10'h169);
        chk_opts(16'h6639);
        meas(1'b0, per(6));
        meas(1'b1, per(6));
        put(8'h41, 8'h41);
        u_host.send(8'h0E);
        put(8'h42, 8'hC2);
        put(8'h5A, 8'hDA);
        u_host.send(8'h0F);
        repeat (8)
        begin
            b = {2'b01, 6'($random(seed))};
            put(b, b);
        end
        u_host.idle();
        $display("done: shift codes");
        put(8'h0C, 8'h0C);
        u_host.idle();
        #1;
        chk_bit(init_pulse_o, 1'b1);
        @(posedge core_clk_i);
        #2;
        chk_bit(init_pulse_o, 1'b0);
        chk_bit(fill_busy_o, 1'b1);
        repeat (20) @(posedge core_clk_i);
        #2;
        chk_bit(fill_busy_o, 1'b1);
        $display("done: form feed");
        do_reset(4'h8, 4'h7, 10'h292);
        chk_opts(16'h87C2);
        opt = 10'h169;
        tx_rate_strap_i = 4'h6;
        rx_rate_strap_i = 4'h6;
        meas(1'b0, per(8));
        meas(1'b1, per(7));
        chk_opts(16'h87C2);
        put(8'h8C, 8'h8C);
        repeat (12)
        begin
            b = 8'($random(seed));
            b[0] = (b[6:0] == 7'h0C) ? 1'b1 : b[0];
            put(b, b);
        end
        u_host.idle();
        $display("done: bit eight split rates");
        do_reset(4'h1, 4'h2, 10'h16D);
        chk_opts(16'h123D);
        meas(1'b0, per(1));
        meas(1'b1, per(2));
        $display("done: low rates");
        do_reset(4'h4, 4'h5, 10'h3D6);
        chk_opts(16'h4500);
        meas(1'b0, per(4));
        meas(1'b1, per(5));
        $display("done: mid rates and conflicting posts");
        ext_run = 1'b1;
        do_reset(4'h3, 4'h9, 10'h169);
        chk_opts(16'h3939);
        meas(1'b0, 100.06);
        meas(1'b1, 100.06);
        ext_run = 1'b0;
        chk_bit(exp_q.size() == 0, 1'b1);
        $display("done: external clock");
        results();
    end
endmodule

// ---- bcs_top.sv ----
// strap-configured baud clocking and option selection
module bcs_top
(
    // clock and reset
    input  wire logic          core_clk_i,
    input  wire logic          reset_n_i,
    // straps, sampled a few cycles after reset release
    input  wire logic [3:0]    tx_rate_strap_i,
    input  wire logic [3:0]    rx_rate_strap_i,
    input  wire logic          bit_eight_source_post_i,
    input  wire logic          shift_code_source_post_i,
    input  wire logic          reverse_attr_post_i,
    input  wire logic          blink_attr_post_i,
    input  wire logic          screen_polarity_strap_i,
    input  wire logic          half_intensity_disable_strap_i,
    input  wire logic          charset_select_strap_i,
    input  wire logic [1:0]    parity_strap_i,
    input  wire logic          formfeed_init_strap_i,
    // serial port external clock pin
    input  wire logic          ext_clk_pin_i,
    // received characters from the serial receiver
    input  wire logic          rx_valid_i,
    input  wire logic [7:0]    rx_data_i,
    // bit-rate enables
    output logic               tx_tick_o,
    output logic               rx_tick_o,
    // decoded settings
    output bcs_pkg::bcs_cfg_t  cfg_o,
    output logic               attr_blink_o,
    output logic               attr_reverse_o,
    // character path
    output logic               char_valid_o,
    output logic [6:0]         char_code_o,
    output logic               char_attr_o,
    // remote initialisation
    output logic               init_pulse_o,
    output logic               fill_busy_o
);
    logic [8:0]        rate_tick;
    logic [12:0]       strap_sync1;
    logic [12:0]       strap_sync2;
    logic [1:0]        cap_cnt;
    logic              captured;
    logic [2:0]        ext_sync;
    logic              ext_edge;
    logic              tx_sel_tick;
    logic              rx_sel_tick;
    logic [21:0]       fill_cnt;
    logic              init_raw;
    bcs_pkg::bcs_cfg_t next_cfg;
    bcs_pkg::bcs_cfg_t cfg;

    // rate code to tick; codes beyond the table give no tick
    function automatic logic pick_tick(input logic [3:0] code, input logic [8:0] ticks);
        pick_tick = (code < 4'h9) ? ticks[code] : 1'b0;
    endfunction

    bcs_rate_divider u_div
    (
        .core_clk_i  (core_clk_i),
        .reset_n_i   (reset_n_i),
        .rate_tick_o (rate_tick)
    );

    // straps and the clock pin are asynchronous; two stages before use
    always_ff @(posedge core_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            strap_sync1 <= 13'h0000;
            strap_sync2 <= 13'h0000;
            ext_sync    <= 3'h0;
        end
        else
        begin
            strap_sync1 <= {bit_eight_source_post_i, shift_code_source_post_i,
                            reverse_attr_post_i, blink_attr_post_i,
                            screen_polarity_strap_i, half_intensity_disable_strap_i,
                            charset_select_strap_i, parity_strap_i,
                            formfeed_init_strap_i, 3'h0};
            strap_sync2 <= strap_sync1;
            ext_sync    <= {ext_sync[1:0], ext_clk_pin_i};
        end
    end

    // rate straps: separate two-stage pair
    logic [7:0] rate_sync1;
    logic [7:0] rate_sync2;
    always_ff @(posedge core_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            rate_sync1 <= 8'h00;
            rate_sync2 <= 8'h00;
        end
        else
        begin
            rate_sync1 <= {tx_rate_strap_i, rx_rate_strap_i};
            rate_sync2 <= rate_sync1;
        end
    end

    // decode straps; shift codes win when both or neither source posted
    always_comb
    begin
        next_cfg                 = cfg;
        next_cfg.tx_rate         = rate_sync2[7:4];
        next_cfg.rx_rate         = rate_sync2[3:0];
        next_cfg.src_bit_eight   = strap_sync2[12] && !strap_sync2[11];
        next_cfg.attr_reverse    = strap_sync2[10] && !strap_sync2[9];
        next_cfg.forward_video   = strap_sync2[8];
        next_cfg.half_int_enable = !strap_sync2[7];
        next_cfg.charset_std     = strap_sync2[6];
        unique case (strap_sync2[5:4])
            2'b01:   next_cfg.parity = bcs_pkg::BCS_PAR_ODD;
            2'b10:   next_cfg.parity = bcs_pkg::BCS_PAR_EVEN;
            default: next_cfg.parity = bcs_pkg::BCS_PAR_NONE;
        endcase
        next_cfg.ff_init_enable  = strap_sync2[3];
    end

    // capture once, a few cycles after release, then freeze; default
    // values mirror the factory strapping until capture
    always_ff @(posedge core_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            cap_cnt  <= 2'h0;
            captured <= 1'b0;
            cfg      <= '{tx_rate: bcs_pkg::RATE_9600, rx_rate: bcs_pkg::RATE_9600,
                          src_bit_eight: 1'b0, attr_reverse: 1'b0,
                          forward_video: 1'b1, half_int_enable: 1'b1,
                          charset_std: 1'b1, parity: bcs_pkg::BCS_PAR_NONE,
                          ff_init_enable: 1'b1};
        end
        else if (!captured)
        begin
            cap_cnt <= cap_cnt + 2'h1;
            if (cap_cnt == 2'h3)
            begin
                captured <= 1'b1;
                cfg      <= next_cfg;
            end
        end
    end

    // external clock: rising edge of the synchronised pin feeds both sides
    assign ext_edge    = ext_sync[1] && !ext_sync[2];
    assign tx_sel_tick = (cfg.tx_rate == bcs_pkg::RATE_EXT || cfg.rx_rate == bcs_pkg::RATE_EXT)
                         ? ext_edge : pick_tick(cfg.tx_rate, rate_tick);
    assign rx_sel_tick = (cfg.tx_rate == bcs_pkg::RATE_EXT || cfg.rx_rate == bcs_pkg::RATE_EXT)
                         ? ext_edge : pick_tick(cfg.rx_rate, rate_tick);

    // registered enables, one cycle wide
    always_ff @(posedge core_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            tx_tick_o <= 1'b0;
            rx_tick_o <= 1'b0;
        end
        else
        begin
            tx_tick_o <= captured && tx_sel_tick;
            rx_tick_o <= captured && rx_sel_tick;
        end
    end

    assign cfg_o          = cfg;
    assign attr_blink_o   = !cfg.attr_reverse;
    assign attr_reverse_o = cfg.attr_reverse;

    bcs_attr_ctrl u_attr
    (
        .core_clk_i       (core_clk_i),
        .reset_n_i        (reset_n_i),
        .src_bit_eight_i  (cfg.src_bit_eight),
        .ff_init_enable_i (cfg.ff_init_enable),
        .rx_valid_i       (rx_valid_i && captured),
        .rx_data_i        (rx_data_i),
        .char_valid_o     (char_valid_o),
        .char_code_o      (char_code_o),
        .char_attr_o      (char_attr_o),
        .init_pulse_o     (init_raw)
    );

    // fill window after form feed; characters in it are the host's fault
    always_ff @(posedge core_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            fill_cnt <= 22'h000000;
        else if (init_raw)
            fill_cnt <= 22'(bcs_pkg::FILL_CYC);
        else if (fill_cnt != 22'h000000)
            fill_cnt <= fill_cnt - 22'h000001;
    end

    assign init_pulse_o = init_raw;
    assign fill_busy_o  = fill_cnt != 22'h000000;

    property p_tick_one_cycle;
        @(posedge core_clk_i) disable iff (!reset_n_i)
        tx_tick_o |=> !tx_tick_o;
    endproperty
    a_tick_one_cycle: assert property (p_tick_one_cycle) else $error("tx tick too wide");

    property p_same_rate;
        @(posedge core_clk_i) disable iff (!reset_n_i)
        (cfg.tx_rate == cfg.rx_rate) |-> (tx_tick_o == rx_tick_o);
    endproperty
    a_same_rate: assert property (p_same_rate) else $error("shared rate ticks differ");

    property p_cfg_frozen;
        @(posedge core_clk_i) disable iff (!reset_n_i)
        $past(captured) |-> $stable(cfg);
    endproperty
    a_cfg_frozen: assert property (p_cfg_frozen) else $error("config changed after capture");

    property p_fill;
        @(posedge core_clk_i) disable iff (!reset_n_i)
        init_raw |=> fill_busy_o [*8];
    endproperty
    a_fill: assert property (p_fill) else $error("fill window missing");

    property p_fastest;
        @(posedge core_clk_i) disable iff (!reset_n_i)
        rate_tick[8] |=> !rate_tick[8] [*8];
    endproperty
    a_fastest: assert property (p_fastest) else $error("fastest tick spacing short");

    property p_slow_sub;
        @(posedge core_clk_i) disable iff (!reset_n_i)
        rate_tick[0] |-> rate_tick[1] && rate_tick[8];
    endproperty
    a_slow_sub: assert property (p_slow_sub) else $error("chain ticks not nested");

    // type taken from the posts at capture; the two outputs stay complements
    property p_blink_rev;
        @(posedge core_clk_i) disable iff (!reset_n_i)
        $rose(captured)
            |-> (attr_reverse_o == ($past(strap_sync2[10]) && !$past(strap_sync2[9])))
            && (attr_blink_o != attr_reverse_o);
    endproperty
    a_blink_rev: assert property (p_blink_rev) else $error("attribute type ambiguous");

    property p_ff_off;
        @(posedge core_clk_i) disable iff (!reset_n_i)
        !cfg.ff_init_enable |-> !init_raw;
    endproperty
    a_ff_off: assert property (p_ff_off) else $error("init without strap");

    property p_rx_one_cycle;
        @(posedge core_clk_i) disable iff (!reset_n_i)
        rx_tick_o |=> !rx_tick_o;
    endproperty
    a_rx_one_cycle: assert property (p_rx_one_cycle) else $error("rx tick too wide");

    // either side on the pin puts both sides on it
    property p_ext_shared;
        @(posedge core_clk_i) disable iff (!reset_n_i)
        (cfg.tx_rate == bcs_pkg::RATE_EXT || cfg.rx_rate == bcs_pkg::RATE_EXT)
            |-> (tx_tick_o == rx_tick_o);
    endproperty
    a_ext_shared: assert property (p_ext_shared) else $error("external ticks differ");

    // no tick leaves before the straps are frozen
    property p_no_tick_early;
        @(posedge core_clk_i) disable iff (!reset_n_i)
        !captured |-> !tx_tick_o && !rx_tick_o;
    endproperty
    a_no_tick_early: assert property (p_no_tick_early) else $error("tick before capture");

    property p_default_rate;
        @(posedge core_clk_i) disable iff (!reset_n_i)
        captured && (cfg.tx_rate == bcs_pkg::RATE_9600) && (cfg.rx_rate != bcs_pkg::RATE_EXT)
            && rate_tick[bcs_pkg::RATE_9600] |=> tx_tick_o;
    endproperty
    a_default_rate: assert property (p_default_rate) else $error("9600 tick not passed");

    property p_bit_eight_attr;
        @(posedge core_clk_i) disable iff (!reset_n_i)
        captured && cfg.src_bit_eight && rx_valid_i
            |=> char_valid_o && (char_attr_o == $past(rx_data_i[7]));
    endproperty
    a_bit_eight_attr: assert property (p_bit_eight_attr) else $error("bit eight attr lost");

    // in shift-code mode, shift codes steer the attribute and are never shown
    property p_shift_suppress;
        @(posedge core_clk_i) disable iff (!reset_n_i)
        captured && !cfg.src_bit_eight && rx_valid_i
            && (rx_data_i[6:0] == bcs_pkg::CHAR_SO[6:0] || rx_data_i[6:0] == bcs_pkg::CHAR_SI[6:0])
            |=> !char_valid_o;
    endproperty
    a_shift_suppress: assert property (p_shift_suppress) else $error("shift code shown");

    property p_init_src;
        @(posedge core_clk_i) disable iff (!reset_n_i)
        init_raw |-> $past(rx_valid_i) && ($past(rx_data_i[6:0]) == bcs_pkg::CHAR_FF[6:0]);
    endproperty
    a_init_src: assert property (p_init_src) else $error("init without form feed");

    property p_cap_video;
        @(posedge core_clk_i) disable iff (!reset_n_i)
        $rose(captured)
            |-> (cfg.forward_video == $past(strap_sync2[8]))
            && (cfg.half_int_enable == !$past(strap_sync2[7]))
            && (cfg.charset_std == $past(strap_sync2[6]));
    endproperty
    a_cap_video: assert property (p_cap_video) else $error("video straps misread");

    property p_src_excl;
        @(posedge core_clk_i) disable iff (!reset_n_i)
        $rose(captured)
            |-> (cfg.src_bit_eight == ($past(strap_sync2[12]) && !$past(strap_sync2[11])));
    endproperty
    a_src_excl: assert property (p_src_excl) else $error("attribute source misread");

    c_tx_tick:  cover property (@(posedge core_clk_i) tx_tick_o);
    c_init:     cover property (@(posedge core_clk_i) init_raw);
    c_attr_set: cover property (@(posedge core_clk_i) char_valid_o && char_attr_o);
    c_ext_tick: cover property (@(posedge core_clk_i) cfg.rx_rate == bcs_pkg::RATE_EXT && rx_tick_o);
    c_split:    cover property (@(posedge core_clk_i) captured && tx_tick_o && !rx_tick_o);
endmodule
